// ### pkg/cat_pkg.sv
/*
 * Shared constants of the counter array timebase: register addresses,
 * mode register fields, timebase select codes and divide ratios.
 * Assumes an 8-bit special function register port on the core side.
 */
package cat_pkg;

   // Register addresses on the special function register port
   localparam logic [7:0] CAT_ADDR_LOW   = 8'he9;
   localparam logic [7:0] CAT_ADDR_HIGH  = 8'hf9;
   localparam logic [7:0] CAT_ADDR_MODE  = 8'hd9;

   // Mode register field positions
   localparam int CAT_MODE_IRQ_EN    = 0;
   localparam int CAT_MODE_SEL_LSB   = 1;
   localparam int CAT_MODE_SEL_MSB   = 3;
   localparam int CAT_MODE_OVF       = 6;
   localparam int CAT_MODE_IDLE_STOP = 7;

   // Reset values and the counter maximum
   localparam logic [7:0]  CAT_MODE_RESET  = 8'h00;
   localparam logic [15:0] CAT_COUNT_RESET = 16'h0000;
   localparam logic [15:0] CAT_COUNT_MAX   = 16'hffff;
   localparam logic [7:0]  CAT_RDATA_ZERO  = 8'h00;

   // Timebase select codes
   localparam logic [2:0] CAT_SEL_DIV12  = 3'h0;
   localparam logic [2:0] CAT_SEL_DIV4   = 3'h1;
   localparam logic [2:0] CAT_SEL_T0OVF  = 3'h2;
   localparam logic [2:0] CAT_SEL_EXTIN  = 3'h3;
   localparam logic [2:0] CAT_SEL_SYSTEM_CLOCK = 3'h4;
   localparam logic [2:0] CAT_SEL_EXTOSC = 3'h5;

   // Divide ratios
   localparam int CAT_SYS_DIV_SLOW = 12;
   localparam int CAT_SYS_DIV_FAST = 4;
   localparam int CAT_EXT_DIV      = 8;

   typedef logic [2:0] cat_sel_t;

endpackage

// ### design/cat_prescale.sv
/*
 * System clock prescaler: one-cycle enable pulses at the system clock
 * divided by the slow and the fast ratio.
 * Assumes the slow ratio is a multiple of the fast ratio.
 */
`timescale 1ns/100ps
module cat_prescale #(
   parameter int DIV_SLOW = cat_pkg::CAT_SYS_DIV_SLOW,
   parameter int DIV_FAST = cat_pkg::CAT_SYS_DIV_FAST
) (
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic rstn,
   // Enable pulses
   output logic      tick_slow,
   output logic      tick_fast
);
   import cat_pkg::*;

   localparam int CW = $clog2(DIV_SLOW);
   localparam logic [CW-1:0] LAST_SLOW = CW'(DIV_SLOW - 1);
   localparam logic [CW-1:0] FAST_MASK = CW'(DIV_FAST - 1);
   localparam logic [CW-1:0] ZERO      = '0;
   localparam logic [CW-1:0] ONE       = CW'(1);

   logic [CW-1:0] phase;
   wire           wrap_slow = (phase == LAST_SLOW);
   wire           wrap_fast = ((phase & FAST_MASK) == FAST_MASK);
   wire [CW-1:0]  next_phase = wrap_slow ? ZERO : phase + ONE;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         phase     <= '0;
         tick_slow <= 1'b0;
         tick_fast <= 1'b0;
      end else begin
         phase     <= next_phase;
         tick_slow <= wrap_slow;
         tick_fast <= wrap_fast;
      end
   end
endmodule

// ### design/cat_extdiv.sv
/*
 * External oscillator divider: synchronises the oscillator into the
 * system clock domain and pulses once every DIV of its rising edges.
 * Assumes the oscillator is well below half the system clock rate.
 */
`timescale 1ns/100ps
module cat_extdiv #(
   parameter int DIV = cat_pkg::CAT_EXT_DIV
) (
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic rstn,
   // Oscillator in, divided pulse out
   input  wire logic ext_osc,
   output logic      tick
);
   import cat_pkg::*;

   localparam int DW = $clog2(DIV);
   localparam logic [DW-1:0] LAST = DW'(DIV - 1);
   localparam logic [DW-1:0] ONE  = DW'(1);

   logic          sync_a;
   logic          sync_b;
   logic          sync_c;
   logic [DW-1:0] edges;
   wire           rise      = sync_b & ~sync_c;
   wire           last_edge = rise & (edges == LAST);

   // Second stage only feeds the edge detector; first stage stays private
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
         sync_c <= 1'b0;
         edges  <= '0;
         tick   <= 1'b0;
      end else begin
         sync_a <= ext_osc;
         sync_b <= sync_a;
         sync_c <= sync_b;
         if (rise)
            edges <= edges + ONE;
         tick <= last_edge;
      end
   end
endmodule

// ### design/cat_top.sv
/*
 * Counter array timebase: a 16-bit free-running up-counter seen as two
 * byte registers plus a mode register on the special function register
 * port, with a coherent-read snapshot of the high byte, a selectable
 * count source, an overflow flag and its interrupt request.
 * Assumes the register port is synchronous to sys_clk, read and write
 * strobes last one cycle, and all pin inputs except ext_osc are synchronous.
 */
// Functional notes
// - 16-bit up-counter exposed as low byte and high byte registers.
// - Low byte read latches high byte; next high read returns that latch.
// - Reads of either byte never disturb counting.
// - Select 000 system_clock/12, 001 system_clock/4, 010 timer0 overflow, 100 system_clock.
// - Select 011 counts external input falling edges, max system_clock/4.
// - Select 101 counts external oscillator/8, synchronised to system_clock.
// - Wrap from all ones to zero sets the overflow flag.
// - Interrupt request only while overflow flag and its enable are set.
// - Flag not cleared by interrupt vectoring; software clears it.
// - Idle-stop clear: counter keeps running in idle mode.
`timescale 1ns/100ps
module cat_top (
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rstn,

   // Register port
   input  wire logic [7:0] sfr_addr,
   input  wire logic       sfr_rd,
   input  wire logic       sfr_wr,
   input  wire logic [7:0] sfr_wdata,
   output logic      [7:0] sfr_rdata,

   // Count sources
   input  wire logic       timer0_overflow,
   input  wire logic       external_count_input,
   input  wire logic       ext_osc,

   // Power state
   input  wire logic       cpu_idle,

   // Status and request
   output logic [15:0]     count_value,
   output logic            overflow_flag,
   output logic            overflow_irq
);
   import cat_pkg::*;

   // Mode register fields
   logic       overflow_irq_enable;
   logic       idle_stop_control;
   cat_sel_t   timebase_select;

   // Snapshot of the high byte and its validity
   logic [7:0] snapshot;
   logic       snapshot_armed;

   // External input history for edge detection
   logic       ext_in_prev;

   // Prescaler and oscillator pulses
   logic       tick_div12;
   logic       tick_div4;
   logic       tick_extosc;

   // Address decode
   wire hit_low  = (sfr_addr == CAT_ADDR_LOW);
   wire hit_high = (sfr_addr == CAT_ADDR_HIGH);
   wire hit_mode = (sfr_addr == CAT_ADDR_MODE);

   wire rd_low   = sfr_rd & hit_low;
   wire rd_high  = sfr_rd & hit_high;
   wire rd_mode  = sfr_rd & hit_mode;
   wire wr_low   = sfr_wr & hit_low;
   wire wr_high  = sfr_wr & hit_high;
   wire wr_mode  = sfr_wr & hit_mode;

   // Prescaler for the divided system clock sources
   cat_prescale #(
      .DIV_SLOW (CAT_SYS_DIV_SLOW),
      .DIV_FAST (CAT_SYS_DIV_FAST)
   ) u_prescale (
      .sys_clk   (sys_clk),
      .rstn      (rstn),
      .tick_slow (tick_div12),
      .tick_fast (tick_div4)
   );

   cat_extdiv #(
      .DIV (CAT_EXT_DIV)
   ) u_extdiv (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .ext_osc (ext_osc),
      .tick    (tick_extosc)
   );

   // Falling edge of external input
   // Input assumed no faster than system_clock/4, so one sample per level suffices
   wire ext_fall = ext_in_prev & ~external_count_input;

   logic source_tick;
   always_comb begin
      case (timebase_select)
         CAT_SEL_DIV12:  source_tick = tick_div12;
         CAT_SEL_DIV4:   source_tick = tick_div4;
         CAT_SEL_T0OVF:  source_tick = timer0_overflow;
         CAT_SEL_EXTIN:  source_tick = ext_fall;
         CAT_SEL_SYSTEM_CLOCK: source_tick = 1'b1;
         CAT_SEL_EXTOSC: source_tick = tick_extosc;
         default:        source_tick = 1'b0;
      endcase
   end

   wire idle_hold = cpu_idle & idle_stop_control;
   wire count_en  = source_tick & ~idle_hold;

   // Next count value
   // A byte write wins over a count in the same cycle
   wire [15:0] count_inc  = count_value + 16'h0001;
   wire [15:0] next_count = wr_low  ? {count_value[15:8], sfr_wdata} :
                            wr_high ? {sfr_wdata, count_value[7:0]} :
                            count_en ? count_inc : count_value;

   wire wrap = count_en & ~wr_low & ~wr_high & (count_value == CAT_COUNT_MAX);

   // Flag clears only by software write; wrap wins over the clear
   wire next_flag = wrap | (wr_mode ? sfr_wdata[CAT_MODE_OVF] : overflow_flag);

   wire next_irq_enable = wr_mode ? sfr_wdata[CAT_MODE_IRQ_EN] : overflow_irq_enable;
   wire next_irq        = next_flag & next_irq_enable;

   // Mode register read image
   wire [7:0] mode_image = {idle_stop_control,
                            overflow_flag,
                            2'b00,
                            timebase_select,
                            overflow_irq_enable};

   // Reads touch only the read path
   wire [7:0] high_view  = snapshot_armed ? snapshot : count_value[15:8];
   wire [7:0] next_rdata = rd_low  ? count_value[7:0] :
                           rd_high ? high_view :
                           rd_mode ? mode_image :
                           CAT_RDATA_ZERO;

   wire next_armed = rd_low | (snapshot_armed & ~rd_high);

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn)
         count_value <= CAT_COUNT_RESET;
      else
         count_value <= next_count;
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         overflow_flag <= 1'b0;
         overflow_irq  <= 1'b0;
      end else begin
         overflow_flag <= next_flag;
         overflow_irq  <= next_irq;
      end
   end

   // Mode register control fields
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         overflow_irq_enable <= CAT_MODE_RESET[CAT_MODE_IRQ_EN];
         idle_stop_control   <= CAT_MODE_RESET[CAT_MODE_IDLE_STOP];
         timebase_select     <= CAT_MODE_RESET[CAT_MODE_SEL_MSB:CAT_MODE_SEL_LSB];
      end else if (wr_mode) begin
         overflow_irq_enable <= sfr_wdata[CAT_MODE_IRQ_EN];
         idle_stop_control   <= sfr_wdata[CAT_MODE_IDLE_STOP];
         timebase_select     <= sfr_wdata[CAT_MODE_SEL_MSB:CAT_MODE_SEL_LSB];
      end
   end

   // Snapshot latch on low byte read
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         snapshot       <= CAT_RDATA_ZERO;
         snapshot_armed <= 1'b0;
      end else begin
         snapshot_armed <= next_armed;
         if (rd_low)
            snapshot <= count_value[15:8];
      end
   end

   // Read data register
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn)
         sfr_rdata <= CAT_RDATA_ZERO;
      else
         sfr_rdata <= next_rdata;
   end

   // External input history
   // Reset high so a pin already low at release is seen as a falling edge
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn)
         ext_in_prev <= 1'b1;
      else
         ext_in_prev <= external_count_input;
   end

endmodule

// ### tb/cat_monitor.sv
/* Assertions on the counter array timebase top ports.
   Assumes binding to cat_top; the mode register is shadowed from writes. */
`timescale 1ns/100ps
module cat_monitor
   import cat_pkg::*;
(
   // Clock and reset
   input wire logic        sys_clk,
   input wire logic        rstn,
   // Register port
   input wire logic [7:0]  sfr_addr,
   input wire logic        sfr_rd,
   input wire logic        sfr_wr,
   input wire logic [7:0]  sfr_wdata,
   input wire logic [7:0]  sfr_rdata,
   // Status
   input wire logic        cpu_idle,
   input wire logic [15:0] count_value,
   input wire logic        overflow_flag,
   input wire logic        overflow_irq
);
   logic [7:0] mode_q;
   wire logic  mode_wr   = sfr_wr && sfr_addr == CAT_ADDR_MODE;
   wire logic  hold_idle = cpu_idle && mode_q[CAT_MODE_IDLE_STOP];
   wire logic [2:0] sel  = mode_q[CAT_MODE_SEL_MSB:CAT_MODE_SEL_LSB];

   // Shadow the whole written byte, flag bit included; the flag is watched on its own port
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn)
         mode_q <= CAT_MODE_RESET;
      else if (mode_wr)
         mode_q <= sfr_wdata;
   end

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   wrap_sets_flag_a: assert property (
      $past(count_value) == CAT_COUNT_MAX && count_value == CAT_COUNT_RESET |-> overflow_flag)
      else $error("overflow flag missing after wrap");
   irq_from_flag_a: assert property (
      overflow_irq == (overflow_flag && mode_q[CAT_MODE_IRQ_EN]))
      else $error("interrupt request not flag and enable");
   flag_sticky_a: assert property (
      overflow_flag && !mode_wr |=> overflow_flag)
      else $error("overflow flag cleared without a write");
   rdata_idle_a: assert property (
      !sfr_rd |=> sfr_rdata == CAT_RDATA_ZERO)
      else $error("read data not zero without a read");
   low_read_a: assert property (
      sfr_rd && sfr_addr == CAT_ADDR_LOW |=> sfr_rdata == $past(count_value[7:0]))
      else $error("low byte read wrong");
   system_clock_count_a: assert property (
      sel == CAT_SEL_SYSTEM_CLOCK && !hold_idle && !sfr_wr |=> count_value == $past(count_value) + 16'h0001)
      else $error("counter missed a system clock step");
   idle_hold_a: assert property (
      hold_idle && !sfr_wr |=> $stable(count_value))
      else $error("counter moved while idle stopped");
   undef_hold_a: assert property (
      sel[2:1] == 2'b11 && !sfr_wr |=> $stable(count_value))
      else $error("counter moved on undefined select");
endmodule

// ### tb/test_counter_array_timebase.sv
/* Self-checking bench for the counter array timebase top.
   Assumes cat_pkg, the design and cat_monitor are compiled first. */
`timescale 1ns/100ps
module test_counter_array_timebase;
   import cat_pkg::*;
   logic        sys_clk     = 1'b0;
   logic        rstn        = 1'b0;
   logic [7:0]  sfr_addr    = 8'h00;
   logic        sfr_rd      = 1'b0;
   logic        sfr_wr      = 1'b0;
   logic [7:0]  sfr_wdata   = 8'h00;
   logic        p           = 1'b0;
   logic        cpu_idle    = 1'b0;
   logic [7:0]  md          = 8'h00;
   wire  [7:0]  sfr_rdata;
   wire  [15:0] count_value;
   wire         overflow_flag;
   wire         overflow_irq;
   logic [15:0] c0;
   int          miscompares = 0;
   int          checked     = 0;
   int          n;
   logic [7:0]  tm [8]      = '{8'h00, 8'h02, 8'h08, 8'h0c, 8'h0e, 8'h88, 8'h08, 8'h88};
   int          te [8]      = '{4, 12, 48, 0, 0, 0, 48, 48};
   logic        ti [8]      = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};

   always #4 sys_clk = ~sys_clk;

   // Pulse p reaches only the source that the current mode selects
   cat_top DUT (
      .sys_clk              (sys_clk),
      .rstn                 (rstn),
      .sfr_addr             (sfr_addr),
      .sfr_rd               (sfr_rd),
      .sfr_wr               (sfr_wr),
      .sfr_wdata            (sfr_wdata),
      .sfr_rdata            (sfr_rdata),
      .timer0_overflow      (p && md == 8'h04),
      .external_count_input (!(p && md == 8'h06)),
      .ext_osc              (p && md == 8'h0a),
      .cpu_idle             (cpu_idle),
      .count_value          (count_value),
      .overflow_flag        (overflow_flag),
      .overflow_irq         (overflow_irq)
   );

   task automatic conclude;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge sys_clk);
      sfr_wr = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge sys_clk);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge sys_clk);
      sfr_rd = 1'b0;
      check({8'h00, sfr_rdata}, {8'h00, exp});
   endtask

   task automatic wait_flag;
      n = 0;
      while (overflow_flag !== 1'b1 && n < 100) begin
         @(negedge sys_clk);
         n++;
      end
      if (overflow_flag !== 1'b1) begin
         miscompares++;
         conclude();
      end
   endtask

   // Forty-eight cycles is a whole number of both prescaler periods
   task automatic src(input logic [7:0] m, input int k, input int h, input logic [15:0] e);
      md = m;
      wr(CAT_ADDR_MODE, m);
      c0 = count_value;
      repeat (k) begin
         p = 1'b1;
         repeat (h) @(negedge sys_clk);
         p = 1'b0;
         repeat (4) @(negedge sys_clk);
      end
      repeat (48) @(negedge sys_clk);
      check(count_value - c0, e);
   endtask

   initial begin
      repeat (4) @(negedge sys_clk);
      rstn = 1'b1;
      check(count_value, CAT_COUNT_RESET);
      rd(CAT_ADDR_MODE, CAT_MODE_RESET);
      wr(CAT_ADDR_MODE, 8'h0c);
      wr(CAT_ADDR_HIGH, 8'hff);
      wr(CAT_ADDR_LOW, 8'hfc);
      check(count_value, 16'hfffc);
      rd(CAT_ADDR_LOW, 8'hfc);
      wr(CAT_ADDR_HIGH, 8'h12);
      rd(CAT_ADDR_HIGH, 8'hff);
      rd(CAT_ADDR_HIGH, 8'h12);
      wr(CAT_ADDR_HIGH, 8'hff);
      wr(CAT_ADDR_MODE, 8'h09);
      wait_flag();
      check(count_value, CAT_COUNT_RESET);
      @(negedge sys_clk);
      check(16'(overflow_irq), 16'h0001);
      rd(CAT_ADDR_MODE, 8'h49);
      wr(CAT_ADDR_MODE, 8'h08);
      wr(CAT_ADDR_HIGH, 8'hff);
      wr(CAT_ADDR_LOW, 8'hfe);
      rd(CAT_ADDR_LOW, 8'hff);
      wait_flag();
      check(count_value, CAT_COUNT_RESET);
      repeat (2) @(negedge sys_clk);
      check(16'(overflow_irq), 16'h0000);
      wr(CAT_ADDR_MODE, 8'h00);
      check(16'(overflow_flag), 16'h0000);
      for (int i = 0; i < 8; i++) begin
         cpu_idle = ti[i];
         src(tm[i], 0, 1, te[i]);
      end
      cpu_idle = 1'b0;
      src(8'h04, 5, 1, 16'h0005);
      src(8'h06, 5, 4, 16'h0005);
      src(8'h0a, 16, 4, 16'h0002);
      conclude();
   end
endmodule

bind cat_top cat_monitor mon (
   .sys_clk       (sys_clk),
   .rstn          (rstn),
   .sfr_addr      (sfr_addr),
   .sfr_rd        (sfr_rd),
   .sfr_wr        (sfr_wr),
   .sfr_wdata     (sfr_wdata),
   .sfr_rdata     (sfr_rdata),
   .cpu_idle      (cpu_idle),
   .count_value   (count_value),
   .overflow_flag (overflow_flag),
   .overflow_irq  (overflow_irq)
);
